// >>> inc/sccc_cfg.svh
// Register offsets, field positions and timing counts of the capture/compare array
`ifndef SCCC_CFG_SVH
`define SCCC_CFG_SVH
// =====================================================
// Register offsets
`define SCCC_OFS_CTRL 8'h00
`define SCCC_OFS_RELOAD_A 8'h04
`define SCCC_OFS_RELOAD_B 8'h08
`define SCCC_OFS_TIMER_A 8'h0c
`define SCCC_OFS_TIMER_B 8'h10
`define SCCC_OFS_INT_STATUS 8'h14
`define SCCC_OFS_INT_CLEAR 8'h18
`define SCCC_OFS_INT_ENABLE 8'h1c
`define SCCC_OFS_DOUBLE 8'h20
`define SCCC_REGION_CFG 2'h1
`define SCCC_REGION_VAL 2'h2
// =====================================================
// Field positions
`define SCCC_CTRL_RUN_A 0
`define SCCC_CTRL_RUN_B 1
`define SCCC_CTRL_SEL_A 4:2
`define SCCC_CTRL_SEL_B 7:5
`define SCCC_CTRL_STAGGER 8
`define SCCC_CTRL_W 9
`define SCCC_CFG_COMPARE 0
`define SCCC_CFG_TB_B 1
`define SCCC_CFG_MODE 3:2
`define SCCC_CFG_RISE 4
`define SCCC_CFG_FALL 5
`define SCCC_CFG_SINGLE 6
`define SCCC_CFG_W 7
`define SCCC_INT_W 18
// =====================================================
// Reset values and timing counts
`define SCCC_RST_STATE '0
`define SCCC_STAGGER_LAST 3'h7
`endif

// >>> inc/sccc_pkg.sv
// Types of the capture/compare array
`include "sccc_cfg.svh"
package sccc_pkg;
  typedef enum logic [1:0] {
    SCCC_CMP_INT_MULTI = 2'b00,
    SCCC_CMP_TOGGLE = 2'b01,
    SCCC_CMP_INT_ONCE = 2'b10,
    SCCC_CMP_SET_CLR = 2'b11
  } sccc_cmp_mode_t;
  typedef enum logic [2:0] {
    SCCC_CLK_DIV1 = 3'b000,
    SCCC_CLK_TIMER_OVF = 3'b110,
    SCCC_CLK_EXT = 3'b111
  } sccc_clk_sel_t;
  typedef struct packed {
    logic [15:0] cnt;
    logic upd;
    logic ovf;
    logic [4:0] presc;
    logic ext_prev;
  } sccc_tb_state_t;
  typedef struct packed {
    logic [15:0] val;
    logic pin;
    logic armed;
    logic done;
    logic pin_prev;
    logic evt;
    logic irq;
  } sccc_ch_state_t;
  typedef struct packed {
    logic [`SCCC_CTRL_W-1:0] ctrl;
    logic [15:0] reload_a;
    logic [15:0] reload_b;
    logic [`SCCC_INT_W-1:0] status;
    logic [`SCCC_INT_W-1:0] enable;
    logic [7:0] dbl;
    logic [7:0] dbl_pin;
    logic [15:0][`SCCC_CFG_W-1:0] cfg;
    logic [2:0] phase;
    logic [31:0] prdata;
    logic slverr;
  } sccc_top_state_t;
endpackage

// >>> rtl/sccc_channel.sv
// One capture/compare channel with its pin
`timescale 1ns/1ps
module sccc_channel
  import sccc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Configuration
  input wire logic [`SCCC_CFG_W-1:0] cfg,
  input wire logic cfg_wr,
  input wire logic val_wr,
  input wire logic [15:0] val_data,
  // Time bases
  input wire logic [15:0] cnt_a,
  input wire logic [15:0] cnt_b,
  input wire logic upd_a,
  input wire logic upd_b,
  input wire logic ovf_a,
  input wire logic ovf_b,
  // Pin
  input wire logic pin_i,
  output logic pin_o,
  output logic pin_oe,
  // Events
  output logic [15:0] val,
  output logic evt,
  output logic irq
);
  sccc_ch_state_t s_reg;
  sccc_ch_state_t s_next;
  sccc_cmp_mode_t mode;
  logic [15:0] cnt;
  logic upd, ovf, match, edge_hit, acted;

  // =====================================================
  // Capture and compare
  always_comb
  begin
    s_next = s_reg;
    s_next.evt = 1'b0;
    s_next.irq = 1'b0;
    s_next.pin_prev = pin_i;
    acted = 1'b0;
    mode = sccc_cmp_mode_t'(cfg[`SCCC_CFG_MODE]);
    cnt = cfg[`SCCC_CFG_TB_B] ? cnt_b : cnt_a;
    upd = cfg[`SCCC_CFG_TB_B] ? upd_b : upd_a;
    ovf = cfg[`SCCC_CFG_TB_B] ? ovf_b : ovf_a;
    match = cfg[`SCCC_CFG_COMPARE] && upd && cnt == s_reg.val && !s_reg.done;
    edge_hit = !cfg[`SCCC_CFG_COMPARE] &&
      ((cfg[`SCCC_CFG_RISE] && pin_i && !s_reg.pin_prev) ||
       (cfg[`SCCC_CFG_FALL] && !pin_i && s_reg.pin_prev));
    if (cfg_wr || val_wr)
    begin
      s_next.done = 1'b0;
      s_next.armed = 1'b1;
    end
    if (val_wr)
      s_next.val = val_data;
    if (ovf)
    begin
      s_next.armed = 1'b1;
      if (mode == SCCC_CMP_SET_CLR)
        s_next.pin = 1'b0;
    end
    if (match)
    begin
      case (mode)
        SCCC_CMP_INT_MULTI: acted = 1'b1;
        SCCC_CMP_TOGGLE:
        begin
          acted = 1'b1;
          s_next.pin = !s_reg.pin;
          s_next.evt = 1'b1;
        end
        SCCC_CMP_INT_ONCE: acted = s_reg.armed || ovf;
        SCCC_CMP_SET_CLR:
        begin
          acted = s_reg.armed || ovf;
          if (acted)
            s_next.pin = 1'b1;
        end
        default: acted = 1'b0;
      endcase
      if (acted)
      begin
        s_next.irq = 1'b1;
        s_next.armed = 1'b0;
        s_next.done = cfg[`SCCC_CFG_SINGLE];
      end
    end
    if (edge_hit)
    begin
      s_next.val = cnt;
      s_next.irq = 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      s_reg <= `SCCC_RST_STATE;
    else
      s_reg <= s_next;
  end

  assign pin_o = s_reg.pin;
  assign pin_oe = cfg[`SCCC_CFG_COMPARE] && cfg[2];
  assign val = s_reg.val;
  assign evt = s_reg.evt;
  assign irq = s_reg.irq;

  // =====================================================
  // Checks
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence rise_seen;
    !pin_i ##1 (pin_i && !cfg[`SCCC_CFG_COMPARE] && cfg[`SCCC_CFG_RISE]);
  endsequence
  capture_latch_a: assert property (rise_seen |=> val == $past(cnt) && irq)
    else $error("capture edge not latched");
  toggle_pin_a: assert property ((match && mode == SCCC_CMP_TOGGLE) |=> pin_o != $past(pin_o))
    else $error("toggle mode pin did not invert");
  once_per_period_a: assert property ((match && mode == SCCC_CMP_INT_ONCE && !s_reg.armed
    && !ovf && !cfg_wr && !val_wr) |=> !irq)
    else $error("second interrupt in one period");
  set_clear_a: assert property ((ovf && mode == SCCC_CMP_SET_CLR && !match) |=> !pin_o)
    else $error("overflow did not clear pin");
  single_event_a: assert property ((s_reg.done && !cfg_wr && !val_wr) |=> !evt && !irq)
    else $error("event after single event");
endmodule

// >>> rtl/sccc_timebase.sv
// Reloadable 16-bit time base with selectable count input
`timescale 1ns/1ps
module sccc_timebase
  import sccc_pkg::*;
#(
  parameter bit EXT_ALLOWED = 1'b1
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Control
  input wire logic run,
  input wire logic [2:0] sel,
  input wire logic slot_ok,
  input wire logic [15:0] reload,
  input wire logic load,
  input wire logic [15:0] load_data,
  // Count sources
  input wire logic timer_ovf,
  input wire logic ext_count,
  // Time base
  output logic [15:0] cnt,
  output logic upd,
  output logic ovf
);
  sccc_tb_state_t s_reg;
  sccc_tb_state_t s_next;
  logic tick;
  logic [4:0] mask;

  // =====================================================
  // Count input and counter
  always_comb
  begin
    s_next = s_reg;
    s_next.upd = 1'b0;
    s_next.ovf = 1'b0;
    s_next.presc = s_reg.presc + 5'h01;
    s_next.ext_prev = ext_count;
    mask = (5'h01 << sel) - 5'h01;
    case (sel)
      SCCC_CLK_TIMER_OVF: tick = timer_ovf;
      SCCC_CLK_EXT: tick = EXT_ALLOWED && ext_count && !s_reg.ext_prev;
      default: tick = slot_ok && ((s_reg.presc & mask) == mask);
    endcase
    if (load)
    begin
      s_next.cnt = load_data;
    end
    else if (run && tick)
    begin
      s_next.upd = 1'b1;
      if (s_reg.cnt == 16'hffff)
      begin
        s_next.cnt = reload;
        s_next.ovf = 1'b1;
      end
      else
      begin
        s_next.cnt = s_reg.cnt + 16'h0001;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      s_reg <= `SCCC_RST_STATE;
    else
      s_reg <= s_next;
  end

  assign cnt = s_reg.cnt;
  assign upd = s_reg.upd;
  assign ovf = s_reg.ovf;

  // =====================================================
  // Checks
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  tb_reload_a: assert property (ovf |-> upd && cnt == $past(reload))
    else $error("overflow did not reload time base");
  tb_count_a: assert property ((run && sel == 3'h0 && slot_ok && !load && cnt != 16'hffff)
    |=> upd && cnt == $past(cnt) + 16'h0001)
    else $error("time base did not count");
  tb_ext_a: assert property ((EXT_ALLOWED && run && sel == 3'h7 && !load && $rose(ext_count))
    |=> upd)
    else $error("external count edge missed");
endmodule

// >>> rtl/sccc_top.sv
// Capture/compare array top with APB register file and interrupt
//
// The implementer's own choices: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
module sccc_top
  import sccc_pkg::*;
(
  // Clock and reset
  input wire logic CLOCK,
  input wire logic RESETN,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Count sources
  input wire logic SECOND_TIMER_OVF,
  input wire logic EXT_COUNT_A,
  // Channel pins
  input wire logic [15:0] CC_PIN_I,
  output logic [15:0] CC_PIN_O,
  output logic [15:0] CC_PIN_OE,
  // Interrupt
  output logic INT
);
  sccc_top_state_t s_reg;
  sccc_top_state_t s_next;
  logic [15:0] cnt_a;
  logic [15:0] cnt_b;
  logic upd_a, upd_b, ovf_a, ovf_b;
  logic [15:0][15:0] ch_val;
  logic [15:0] ch_evt;
  logic [15:0] ch_irq;
  logic [15:0] ch_pin;
  logic [15:0] ch_oe;
  logic [7:0] pair_evt;
  logic wr, setup, in_cfg, in_val, slot_ok, rd_err;
  logic [3:0] idx;
  logic [31:0] rd_data;

  // =====================================================
  // Address decode
  assign wr = PSEL && PENABLE && PWRITE;
  assign setup = PSEL && !PENABLE;
  assign idx = PADDR[5:2];
  assign in_cfg = PADDR[7:6] == `SCCC_REGION_CFG && PADDR[1:0] == 2'h0;
  assign in_val = PADDR[7:6] == `SCCC_REGION_VAL && PADDR[1:0] == 2'h0;

  // =====================================================
  // Staggered slot
  assign slot_ok = !s_reg.ctrl[`SCCC_CTRL_STAGGER] ||
    s_reg.phase == `SCCC_STAGGER_LAST;

  // =====================================================
  // Time bases
  sccc_timebase #(
    .EXT_ALLOWED(1'b1)
  ) u_tb_a (
    .clk(CLOCK),
    .rst_n(RESETN),
    .run(s_reg.ctrl[`SCCC_CTRL_RUN_A]),
    .sel(s_reg.ctrl[`SCCC_CTRL_SEL_A]),
    .slot_ok(slot_ok),
    .reload(s_reg.reload_a),
    .load(wr && PADDR == `SCCC_OFS_TIMER_A),
    .load_data(PWDATA[15:0]),
    .timer_ovf(SECOND_TIMER_OVF),
    .ext_count(EXT_COUNT_A),
    .cnt(cnt_a),
    .upd(upd_a),
    .ovf(ovf_a)
  );

  sccc_timebase #(
    .EXT_ALLOWED(1'b0)
  ) u_tb_b (
    .clk(CLOCK),
    .rst_n(RESETN),
    .run(s_reg.ctrl[`SCCC_CTRL_RUN_B]),
    .sel(s_reg.ctrl[`SCCC_CTRL_SEL_B]),
    .slot_ok(slot_ok),
    .reload(s_reg.reload_b),
    .load(wr && PADDR == `SCCC_OFS_TIMER_B),
    .load_data(PWDATA[15:0]),
    .timer_ovf(SECOND_TIMER_OVF),
    .ext_count(1'b0),
    .cnt(cnt_b),
    .upd(upd_b),
    .ovf(ovf_b)
  );

  // =====================================================
  // Channel array
  for (genvar g = 0; g < 16; g++)
  begin : g_ch
    sccc_channel u_ch (
      .clk(CLOCK),
      .rst_n(RESETN),
      .cfg(s_reg.cfg[g]),
      .cfg_wr(wr && in_cfg && idx == 4'(g)),
      .val_wr(wr && in_val && idx == 4'(g)),
      .val_data(PWDATA[15:0]),
      .cnt_a(cnt_a),
      .cnt_b(cnt_b),
      .upd_a(upd_a),
      .upd_b(upd_b),
      .ovf_a(ovf_a),
      .ovf_b(ovf_b),
      .pin_i(CC_PIN_I[g]),
      .pin_o(ch_pin[g]),
      .pin_oe(ch_oe[g]),
      .val(ch_val[g]),
      .evt(ch_evt[g]),
      .irq(ch_irq[g])
    );
  end

  // =====================================================
  // Pin mapping and double register pairs
  assign pair_evt = ch_evt[7:0] ^ ch_evt[15:8];
  assign CC_PIN_O[7:0] = (s_reg.dbl & s_reg.dbl_pin) | (~s_reg.dbl & ch_pin[7:0]);
  assign CC_PIN_OE[7:0] = s_reg.dbl | ch_oe[7:0];
  assign CC_PIN_O[15:8] = ch_pin[15:8];
  assign CC_PIN_OE[15:8] = ~s_reg.dbl & ch_oe[15:8];

  // =====================================================
  // Read decode
  always_comb
  begin
    rd_data = 32'h0000_0000;
    rd_err = 1'b0;
    if (in_cfg)
      rd_data[`SCCC_CFG_W-1:0] = s_reg.cfg[idx];
    else if (in_val)
      rd_data[15:0] = ch_val[idx];
    else
    begin
      case (PADDR)
        `SCCC_OFS_CTRL: rd_data[`SCCC_CTRL_W-1:0] = s_reg.ctrl;
        `SCCC_OFS_RELOAD_A: rd_data[15:0] = s_reg.reload_a;
        `SCCC_OFS_RELOAD_B: rd_data[15:0] = s_reg.reload_b;
        `SCCC_OFS_TIMER_A: rd_data[15:0] = cnt_a;
        `SCCC_OFS_TIMER_B: rd_data[15:0] = cnt_b;
        `SCCC_OFS_INT_STATUS: rd_data[`SCCC_INT_W-1:0] = s_reg.status;
        `SCCC_OFS_INT_CLEAR: rd_data = 32'h0000_0000;
        `SCCC_OFS_INT_ENABLE: rd_data[`SCCC_INT_W-1:0] = s_reg.enable;
        `SCCC_OFS_DOUBLE: rd_data[7:0] = s_reg.dbl;
        default: rd_err = 1'b1;
      endcase
    end
  end

  // =====================================================
  // Register file and interrupt state
  always_comb
  begin
    s_next = s_reg;
    s_next.phase = s_reg.phase + 3'h1;
    s_next.dbl_pin = s_reg.dbl_pin ^ (pair_evt & s_reg.dbl);
    if (wr && in_cfg)
      s_next.cfg[idx] = PWDATA[`SCCC_CFG_W-1:0];
    else if (wr)
    begin
      case (PADDR)
        `SCCC_OFS_CTRL: s_next.ctrl = PWDATA[`SCCC_CTRL_W-1:0];
        `SCCC_OFS_RELOAD_A: s_next.reload_a = PWDATA[15:0];
        `SCCC_OFS_RELOAD_B: s_next.reload_b = PWDATA[15:0];
        `SCCC_OFS_INT_CLEAR: s_next.status = s_reg.status & ~PWDATA[`SCCC_INT_W-1:0];
        `SCCC_OFS_INT_ENABLE: s_next.enable = PWDATA[`SCCC_INT_W-1:0];
        `SCCC_OFS_DOUBLE: s_next.dbl = PWDATA[7:0];
        default: s_next.ctrl = s_reg.ctrl;
      endcase
    end
    s_next.status = s_next.status | {ovf_b, ovf_a, ch_irq};
    if (setup)
    begin
      s_next.prdata = rd_data;
      s_next.slverr = rd_err;
    end
  end

  always_ff @(posedge CLOCK)
  begin
    if (!RESETN)
      s_reg <= `SCCC_RST_STATE;
    else
      s_reg <= s_next;
  end

  // =====================================================
  // Bus and interrupt outputs
  assign PRDATA = s_reg.prdata;
  assign PREADY = 1'b1;
  assign PSLVERR = PSEL && PENABLE && s_reg.slverr;
  assign INT = |(s_reg.status & s_reg.enable);

  // =====================================================
  // Checks
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RESETN);
  stagger_slot_a: assert property ((upd_a && $past(s_reg.ctrl[`SCCC_CTRL_STAGGER])
    && $past(s_reg.ctrl[`SCCC_CTRL_SEL_A]) < 3'h6 && !$past(wr))
    |-> $past(s_reg.phase) == `SCCC_STAGGER_LAST)
    else $error("staggered count off its slot");
  double_pin_a: assert property ((s_reg.dbl[0] && pair_evt[0] && !wr)
    |=> CC_PIN_O[0] != $past(CC_PIN_O[0]) && !CC_PIN_OE[8])
    else $error("double register pin did not toggle");
  irq_sticky_a: assert property ((ch_irq[0] && s_reg.enable[0] && !wr) |=> INT ##1 s_reg.status[0]
    || $past(wr, 1))
    else $error("channel event did not raise interrupt");
  mode0_pin_idle_a: assert property ((s_reg.cfg[1][`SCCC_CFG_MODE] == 2'h0 && !s_reg.dbl[1])
    |-> !CC_PIN_OE[1])
    else $error("interrupt-only channel drives pin");
endmodule

// >>> verification/sccc_pin_model.sv
// Far-side model of the channel pins and the count sources
`timescale 1ns/1ps
module sccc_pin_model
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Bench control
  input wire logic src_en,
  input wire logic [15:0] drive_lvl,
  // Pins
  input wire logic [15:0] pin_o,
  input wire logic [15:0] pin_oe,
  output logic [15:0] pin_i,
  // Count sources
  output logic timer_ovf,
  output logic ext_count
);
  logic [2:0] div_reg = 3'h0;
  logic ovf_reg = 1'b0;
  logic ext_reg = 1'b0;
  // Wire level: device drive wins, else the outside source
  assign pin_i = (pin_oe & pin_o) | (~pin_oe & drive_lvl);
  assign timer_ovf = ovf_reg;
  assign ext_count = ext_reg;
  // Overflow pulse every 5 cycles, external rising edge every 10
  always @(posedge clk)
  begin
    if (!rst_n || !src_en)
    begin
      div_reg <= 3'h0;
      ovf_reg <= 1'b0;
      ext_reg <= 1'b0;
    end
    else
    begin
      div_reg <= (div_reg == 3'h4) ? 3'h0 : div_reg + 3'h1;
      ovf_reg <= (div_reg == 3'h4);
      ext_reg <= (div_reg == 3'h4) ? ~ext_reg : ext_reg;
    end
  end
endmodule

// >>> verification/tb_sixteen_channel_capture_compare.sv
// Self-checking bench of the capture/compare array
`timescale 1ns/1ps
module tb_sixteen_channel_capture_compare;
  logic CLOCK = 1'b0;
  logic RESETN = 1'b0;
  logic PSEL = 1'b0;
  logic PENABLE = 1'b0;
  logic PWRITE = 1'b0;
  logic [7:0] PADDR = 8'h00;
  logic [31:0] PWDATA = 32'h0;
  logic [31:0] PRDATA;
  logic PREADY, PSLVERR, SECOND_TIMER_OVF, EXT_COUNT_A, INT;
  logic [15:0] CC_PIN_I, CC_PIN_O, CC_PIN_OE;
  logic src_en = 1'b0;
  logic [15:0] drive_lvl = 16'h0000;
  logic [31:0] rdata;
  logic rerr;
  logic p0;
  int n_mismatch = 0;
  int n_tests = 0;
  int cyc = 0;
  int c;
  always #20 CLOCK = ~CLOCK;
  sccc_top uut (
    .CLOCK(CLOCK), .RESETN(RESETN), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .SECOND_TIMER_OVF(SECOND_TIMER_OVF), .EXT_COUNT_A(EXT_COUNT_A), .CC_PIN_I(CC_PIN_I),
    .CC_PIN_O(CC_PIN_O), .CC_PIN_OE(CC_PIN_OE), .INT(INT)
  );
  sccc_pin_model pins (
    .clk(CLOCK), .rst_n(RESETN), .src_en(src_en), .drive_lvl(drive_lvl), .pin_o(CC_PIN_O),
    .pin_oe(CC_PIN_OE), .pin_i(CC_PIN_I), .timer_ovf(SECOND_TIMER_OVF), .ext_count(EXT_COUNT_A)
  );
  // ==========================================
  // Common tasks
  task automatic end_of_test();
    if (n_mismatch == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge CLOCK);
    PSEL <= 1'b1;
    PWRITE <= wr;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLOCK);
    PENABLE <= 1'b1;
    do
    begin
      @(posedge CLOCK);
    end
    while (PREADY !== 1'b1);
    rdata = PRDATA;
    rerr = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(nm, exp, rdata);
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge CLOCK);
  endtask
  // Length of one high phase of a pin, in cycles
  task automatic hi_time(input int i, output int t);
    t = 0;
    while (CC_PIN_O[i] !== 1'b0 && t < 1000)
    begin
      @(posedge CLOCK);
      t++;
    end
    t = 0;
    while (CC_PIN_O[i] !== 1'b1 && t < 1000)
    begin
      @(posedge CLOCK);
      t++;
    end
    t = 0;
    while (CC_PIN_O[i] === 1'b1 && t < 1000)
    begin
      @(posedge CLOCK);
      t++;
    end
  endtask
  // ==========================================
  // Scenarios
  task automatic t_reset();
    chk("pin enables", 32'h0, {16'h0, CC_PIN_OE});
    chk("interrupt", 32'h0, {31'h0, INT});
    chk("ready", 32'h1, {31'h0, PREADY});
    rd_chk("control", 8'h00, 32'h0);
    rd_chk("status", 8'h14, 32'h0);
    rd_chk("unmapped", 8'h24, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, rerr});
    apb(1'b0, 8'h41, 32'h0);
    chk("misaligned error", 32'h1, {31'h0, rerr});
  endtask
  task automatic t_compare();
    wr(8'h40, 32'h05);
    wr(8'h80, 32'hfff8);
    wr(8'h44, 32'h0d);
    wr(8'h84, 32'hfff4);
    wr(8'h4c, 32'h01);
    wr(8'h8c, 32'hfff8);
    wr(8'h04, 32'hfff0);
    wr(8'h0c, 32'hfff0);
    wr(8'h1c, 32'h1);
    wr(8'h00, 32'h1);
    hi_time(0, c);
    chk("toggle high time", 32'd16, c);
    hi_time(1, c);
    chk("set clear high time", 32'd12, c);
    chk("pin enables", 32'h3, {16'h0, CC_PIN_OE & 16'h000f});
    chk("interrupt", 32'h1, {31'h0, INT});
    rd_chk("status", 8'h14, 32'h1000b);
    wr(8'h00, 32'h0);
    wr(8'h18, 32'h3ffff);
    rd_chk("cleared status", 8'h14, 32'h0);
    chk("interrupt off", 32'h0, {31'h0, INT});
  endtask
  task automatic t_rate();
    wr(8'h00, 32'h101);
    hi_time(0, c);
    chk("staggered high time", 32'd128, c);
    wr(8'h20, 32'h1);
    wr(8'h60, 32'h05);
    wr(8'h80, 32'hfff4);
    wr(8'ha0, 32'hfffc);
    wr(8'h00, 32'h1);
    hi_time(0, c);
    chk("paired high time", 32'd8, c);
    chk("paired pin enable", 32'h0, {31'h0, CC_PIN_OE[8]});
    wr(8'h20, 32'h0);
    wr(8'h80, 32'hfff8);
    wr(8'h48, 32'h07);
    wr(8'h88, 32'hffff);
    wr(8'h08, 32'hfffe);
    wr(8'h10, 32'hfffe);
    src_en <= 1'b1;
    wr(8'h00, 32'hc2);
    hi_time(2, c);
    chk("time base b high time", 32'd10, c);
    wr(8'h00, 32'h1d);
    hi_time(0, c);
    chk("external count high time", 32'd160, c);
    wr(8'h00, 32'h0);
    src_en <= 1'b0;
  endtask
  task automatic t_capture();
    wr(8'h50, 32'h10);
    wr(8'h54, 32'h20);
    wr(8'h58, 32'h30);
    wr(8'h0c, 32'h1234);
    wr(8'h1c, 32'h0);
    wr(8'h18, 32'h3ffff);
    drive_lvl <= 16'h0070;
    wait_cyc(4);
    rd_chk("rising capture", 8'h90, 32'h1234);
    rd_chk("falling ignores rise", 8'h94, 32'h0);
    rd_chk("both edges rise", 8'h98, 32'h1234);
    rd_chk("capture status", 8'h14, 32'h50);
    chk("masked interrupt", 32'h0, {31'h0, INT});
    wr(8'h0c, 32'h0abc);
    drive_lvl <= 16'h0000;
    wait_cyc(4);
    rd_chk("rise keeps value", 8'h90, 32'h1234);
    rd_chk("falling capture", 8'h94, 32'h0abc);
    rd_chk("both edges fall", 8'h98, 32'h0abc);
    wr(8'h1c, 32'h20);
    wait_cyc(2);
    chk("enabled interrupt", 32'h1, {31'h0, INT});
    rd_chk("clear register", 8'h18, 32'h0);
    wr(8'h18, 32'h70);
    wait_cyc(2);
    chk("cleared interrupt", 32'h0, {31'h0, INT});
    rd_chk("cleared status", 8'h14, 32'h0);
  endtask
  task automatic t_single();
    wr(8'h40, 32'h45);
    wr(8'h0c, 32'hfff0);
    p0 = CC_PIN_O[0];
    wr(8'h00, 32'h1);
    wait_cyc(40);
    chk("single event edge", {31'h0, ~p0}, {31'h0, CC_PIN_O[0]});
    wait_cyc(40);
    chk("single event hold", {31'h0, ~p0}, {31'h0, CC_PIN_O[0]});
    wr(8'h00, 32'h0);
  endtask
  // Mode 2 on channel 3 against mode 0 on channel 7, two runs without overflow
  task automatic t_once();
    wr(8'h4c, 32'h09);
    wr(8'h5c, 32'h01);
    wr(8'h9c, 32'hfff8);
    wr(8'h0c, 32'hfff0);
    wr(8'h18, 32'h3ffff);
    wr(8'h00, 32'h1);
    wait_cyc(9);
    wr(8'h00, 32'h0);
    apb(1'b0, 8'h14, 32'h0);
    chk("first period status", 32'h88, rdata & 32'h88);
    wr(8'h0c, 32'hfff0);
    wr(8'h18, 32'h3ffff);
    wr(8'h00, 32'h1);
    wait_cyc(9);
    wr(8'h00, 32'h0);
    apb(1'b0, 8'h14, 32'h0);
    chk("same period status", 32'h80, rdata & 32'h88);
  endtask
  // ==========================================
  // Main sequence and timeout
  initial
  begin
    repeat (16) @(posedge CLOCK);
    RESETN <= 1'b1;
    @(posedge CLOCK);
    t_reset();
    t_compare();
    t_rate();
    t_capture();
    t_single();
    t_once();
    end_of_test();
  end
  always @(posedge CLOCK)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      n_mismatch++;
      end_of_test();
    end
  end
endmodule
